// ---- include/display_timing_regs.vh ----
// Purpose: register indices, field positions, reset values and timing figures
//          of the synchronous display timing generator
// Assumes: register index is the word index on the plain register port
// Notes:   all edge positions are counted in half base-clock units
//
// Notes on behaviour
// - pixel clock edges sit at a half-clock phase offset from the local start point
// - frame sync edges sit at a half-clock offset from the local start point
// - line sync edges sit at a half-clock offset from the local start point
// - data-valid edges sit at a half-clock offset from where data is placed
// - divisor is base clocks per pixel clock, resolution one sixteenth
// - fractional divisor gives periods of floor or floor+1, averaging the ratio
// - fall and rise points are ceil(2*point/ratio) half base clocks
// - control edges on half-clock boundaries, data only on whole clocks
// - total line length is the period of the line sync counter
// - every waveform comes from a counter with offset, period and edge points
// - encoder stream is 8 bits wide, one component per encoder clock
// - encoder clock is nominally 27 MHz, within ten percent
// - encoder mode drives both syncs active low and data-valid active high
// - encoder mode: line sync falls each row and stays low one clock
// - encoder mode: frame sync falls each field and stays low at least one clock
// - odd field: frame and line sync falls coincide; even field: they do not
// - encoder mode transfers data only while line sync is high
// - all controls derive from the local start point; data is never shifted
// - pixel clock runs continuously while enabled; panel latches on falling edge
`ifndef DISPLAY_TIMING_REGS_VH
`define DISPLAY_TIMING_REGS_VH

// ==========================================================
// register indices
`define REG_CTRL        5'h00
`define REG_DIVISOR     5'h01
`define REG_RATIO       5'h02
`define REG_FALL        5'h03
`define REG_RISE        5'h04
`define REG_PCLK_OFFSET 5'h05
`define REG_LINE_LEN    5'h06
`define REG_HS_OFFSET   5'h07
`define REG_HS_WIDTH    5'h08
`define REG_FRAME_LINES 5'h09
`define REG_VS_OFFSET   5'h0A
`define REG_VS_WIDTH    5'h0B
`define REG_DV_OFFSET   5'h0C
`define REG_DV_WIDTH    5'h0D
`define REG_ROW_FIRST   5'h0E
`define REG_ROW_COUNT   5'h0F
`define REG_STATUS      5'h10

// ==========================================================
// control fields
`define CTRL_ENABLE     0
`define CTRL_ENCODER    1
`define CTRL_PCLK_INV   2
`define CTRL_HS_HIGH    3
`define CTRL_VS_HIGH    4
`define CTRL_DV_HIGH    5
`define DIV_FRAC_BITS   4

// ==========================================================
// reset values
`define RST_CTRL        6'h00
`define RST_DIVISOR     12'h03B
`define RST_RATIO       8'h01
`define RST_FALL        8'h02
`define RST_RISE        8'h04
`define RST_ZERO16      16'h0000
`define RST_ZERO24      24'h00_0000
`define RST_LINE_LEN    16'h0010
`define RST_FRAME_LINES 16'h0004
`define RST_WIDTH       16'h0002

`endif

// ---- rtl/half_step_gen.v ----
// Purpose: one window waveform with half base-clock edge placement
// Assumes: pos advances on the rising edge; on and off are half-clock units
// Notes:   output = posedge flop xor negedge flop, so each half toggles cleanly
`timescale 1ns/100ps
module half_step_gen
(
   mclk,
   resetn,
   pos,
   onHalf,
   offHalf,
   gate,
   actLevel,
   pinOut
);
   input  wire        mclk;
   input  wire        resetn;
   input  wire [23:0] pos;
   input  wire [24:0] onHalf;
   input  wire [24:0] offHalf;
   input  wire        gate;
   input  wire        actLevel;
   output wire        pinOut;

   reg         posPh_r;
   reg         negPh_r;
   reg         lateLvl_r;
   wire [24:0] halfEarly;
   wire [24:0] halfLate;
   wire        winEarly;
   wire        winLate;
   wire        lvlEarly;
   wire        lvlLate;

   // ==========================================================
   // window test for both halves of the current base clock
   assign halfEarly = {pos, 1'b0};
   assign halfLate  = {pos, 1'b1};
   assign winEarly  = gate && (halfEarly >= onHalf) && (halfEarly < offHalf);
   assign winLate   = gate && (halfLate >= onHalf) && (halfLate < offHalf);
   assign lvlEarly  = winEarly ? actLevel : ~actLevel;
   assign lvlLate   = winLate ? actLevel : ~actLevel;

   // ==========================================================
   // half-clock output stage
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         posPh_r   <= 1'b0;
         lateLvl_r <= 1'b0;
      end
      else
      begin
         posPh_r   <= lvlEarly ^ negPh_r;
         lateLvl_r <= lvlLate;
      end
   end

   // the late half is held from the rising edge so it matches the early half
   always @(negedge mclk or negedge resetn)
   begin
      if (!resetn)
         negPh_r <= 1'b0;
      else
         negPh_r <= lateLvl_r ^ posPh_r;
   end

   assign pinOut = posPh_r ^ negPh_r;
endmodule // half_step_gen

// ---- rtl/sync_display_timing.v ----
// Purpose: synchronous display timing generator for TFT panels and a TV encoder
// Assumes: one base clock mclk; software configures before setting enable
// Notes:   edge figures are in half base-clocks, data moves on whole clocks
`timescale 1ns/100ps
`include "display_timing_regs.vh"
module sync_display_timing
(
   mclk,
   resetn,
   regAddr,
   regWdata,
   regWrite,
   regRead,
   regRdata,
   pixelIn,
   pixelTake,
   pixelData,
   panelPixelClock,
   lineSync,
   frameSync,
   dataValidStrobe
);
   input  wire        mclk;
   input  wire        resetn;
   input  wire [4:0]  regAddr;
   input  wire [31:0] regWdata;
   input  wire        regWrite;
   input  wire        regRead;
   output reg  [31:0] regRdata;
   input  wire [7:0]  pixelIn;
   output wire        pixelTake;
   output reg  [7:0]  pixelData;
   output wire        panelPixelClock;
   output wire        lineSync;
   output wire        frameSync;
   output wire        dataValidStrobe;

   // ==========================================================
   // configuration registers
   reg  [5:0]  ctrl_r;
   reg  [11:0] divisor_r;
   reg  [7:0]  ratio_r;
   reg  [7:0]  fallPoint_r;
   reg  [7:0]  risePoint_r;
   reg  [15:0] pclkOffset_r;
   reg  [15:0] lineLen_r;
   reg  [15:0] hsOffset_r;
   reg  [15:0] hsWidth_r;
   reg  [15:0] frameLines_r;
   reg  [23:0] vsOffset_r;
   reg  [23:0] vsWidth_r;
   reg  [15:0] dvOffset_r;
   reg  [15:0] dvWidth_r;
   reg  [15:0] rowFirst_r;
   reg  [15:0] rowCount_r;

   // ==========================================================
   // timing state
   reg  [7:0]  pixCnt_r;
   reg  [7:0]  pixLen_r;
   reg  [3:0]  fracAcc_r;
   reg  [15:0] lineCnt_r;
   reg  [15:0] lineIdx_r;
   reg  [23:0] framePos_r;
   reg         field_r;

   wire        enable;
   wire        encMode;
   wire [7:0]  divInt;
   wire [3:0]  divFrac;
   wire [4:0]  fracSum;
   wire [7:0]  pixLenNxt;
   wire        pixWrap;
   wire        lineWrap;
   wire        frameWrap;
   wire        rowActive;
   wire        encHsLow;
   wire [16:0] lineHalf;
   wire        dvWhole;
   wire [9:0]  fallHalf;
   wire [9:0]  riseHalf;
   wire [24:0] pclkOn;
   wire [24:0] pclkOff;
   wire [24:0] hsOn;
   wire [24:0] hsOff;
   wire [24:0] vsOn;
   wire [24:0] vsOff;
   wire [24:0] dvOn;
   wire [24:0] dvOff;
   wire        hsAct;
   wire        vsAct;
   wire        dvAct;

   // rounds twice the point over the ratio up, giving half base-clocks
   function [9:0] ceilHalf;
      input [7:0] point;
      input [7:0] ratio;
      reg   [9:0] num;
      begin
         num = {1'b0, point, 1'b0};
         if (ratio == 8'h00)
            ceilHalf = num;
         else
            ceilHalf = (num + {2'b00, ratio} - 10'h001) / {2'b00, ratio};
      end
   endfunction

   // widens a 16-bit figure to the half-clock position width
   function [24:0] widen;
      input [15:0] val;
      begin
         widen = {9'h000, val};
      end
   endfunction

   assign enable  = ctrl_r[`CTRL_ENABLE];
   assign encMode = ctrl_r[`CTRL_ENCODER];

   // ==========================================================
   // register port
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl_r       <= `RST_CTRL;
         divisor_r    <= `RST_DIVISOR;
         ratio_r      <= `RST_RATIO;
         fallPoint_r  <= `RST_FALL;
         risePoint_r  <= `RST_RISE;
         pclkOffset_r <= `RST_ZERO16;
         lineLen_r    <= `RST_LINE_LEN;
         hsOffset_r   <= `RST_ZERO16;
         hsWidth_r    <= `RST_WIDTH;
         frameLines_r <= `RST_FRAME_LINES;
         vsOffset_r   <= `RST_ZERO24;
         vsWidth_r    <= {8'h00, `RST_WIDTH};
         dvOffset_r   <= `RST_ZERO16;
         dvWidth_r    <= `RST_ZERO16;
         rowFirst_r   <= `RST_ZERO16;
         rowCount_r   <= `RST_ZERO16;
      end
      else if (regWrite)
      begin
         case (regAddr)
            `REG_CTRL:        ctrl_r       <= regWdata[5:0];
            `REG_DIVISOR:     divisor_r    <= regWdata[11:0];
            `REG_RATIO:       ratio_r      <= regWdata[7:0];
            `REG_FALL:        fallPoint_r  <= regWdata[7:0];
            `REG_RISE:        risePoint_r  <= regWdata[7:0];
            `REG_PCLK_OFFSET: pclkOffset_r <= regWdata[15:0];
            `REG_LINE_LEN:    lineLen_r    <= regWdata[15:0];
            `REG_HS_OFFSET:   hsOffset_r   <= regWdata[15:0];
            `REG_HS_WIDTH:    hsWidth_r    <= regWdata[15:0];
            `REG_FRAME_LINES: frameLines_r <= regWdata[15:0];
            `REG_VS_OFFSET:   vsOffset_r   <= regWdata[23:0];
            `REG_VS_WIDTH:    vsWidth_r    <= regWdata[23:0];
            `REG_DV_OFFSET:   dvOffset_r   <= regWdata[15:0];
            `REG_DV_WIDTH:    dvWidth_r    <= regWdata[15:0];
            `REG_ROW_FIRST:   rowFirst_r   <= regWdata[15:0];
            `REG_ROW_COUNT:   rowCount_r   <= regWdata[15:0];
            default:          ctrl_r       <= ctrl_r;
         endcase
      end
   end

   // read data stands in the cycle after the strobe only
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         regRdata <= 32'h0000_0000;
      else if (!regRead)
         regRdata <= 32'h0000_0000;
      else
      begin
         case (regAddr)
            `REG_CTRL:        regRdata <= {26'h000_0000, ctrl_r};
            `REG_DIVISOR:     regRdata <= {20'h0_0000, divisor_r};
            `REG_RATIO:       regRdata <= {24'h00_0000, ratio_r};
            `REG_FALL:        regRdata <= {24'h00_0000, fallPoint_r};
            `REG_RISE:        regRdata <= {24'h00_0000, risePoint_r};
            `REG_PCLK_OFFSET: regRdata <= {16'h0000, pclkOffset_r};
            `REG_LINE_LEN:    regRdata <= {16'h0000, lineLen_r};
            `REG_HS_OFFSET:   regRdata <= {16'h0000, hsOffset_r};
            `REG_HS_WIDTH:    regRdata <= {16'h0000, hsWidth_r};
            `REG_FRAME_LINES: regRdata <= {16'h0000, frameLines_r};
            `REG_VS_OFFSET:   regRdata <= {8'h00, vsOffset_r};
            `REG_VS_WIDTH:    regRdata <= {8'h00, vsWidth_r};
            `REG_DV_OFFSET:   regRdata <= {16'h0000, dvOffset_r};
            `REG_DV_WIDTH:    regRdata <= {16'h0000, dvWidth_r};
            `REG_ROW_FIRST:   regRdata <= {16'h0000, rowFirst_r};
            `REG_ROW_COUNT:   regRdata <= {16'h0000, rowCount_r};
            `REG_STATUS:      regRdata <= {15'h0000, field_r, lineIdx_r};
            default:          regRdata <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // fractional pixel clock period
   assign divInt    = divisor_r[11:4];
   assign divFrac   = divisor_r[3:0];
   assign fracSum   = {1'b0, fracAcc_r} + {1'b0, divFrac};
   // carry out of the sixteenths lengthens one period by a whole clock
   assign pixLenNxt = divInt + {7'h00, fracSum[`DIV_FRAC_BITS]};
   assign pixWrap   = ({1'b0, pixCnt_r} + 9'h001) >= {1'b0, pixLen_r};

   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         pixCnt_r  <= 8'h00;
         pixLen_r  <= 8'h00;
         fracAcc_r <= 4'h0;
      end
      else if (!enable)
      begin
         pixCnt_r  <= 8'h00;
         pixLen_r  <= divInt;
         fracAcc_r <= 4'h0;
      end
      else if (pixWrap)
      begin
         pixCnt_r  <= 8'h00;
         pixLen_r  <= pixLenNxt;
         fracAcc_r <= fracSum[3:0];
      end
      else
         pixCnt_r <= pixCnt_r + 8'h01;
   end

   // ==========================================================
   // line and frame counters; line start is the local start point
   assign lineWrap  = ({1'b0, lineCnt_r} + 17'h0_0001) >= {1'b0, lineLen_r};
   assign frameWrap = lineWrap && (({1'b0, lineIdx_r} + 17'h0_0001) >= {1'b0, frameLines_r});

   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         lineCnt_r  <= 16'h0000;
         lineIdx_r  <= 16'h0000;
         framePos_r <= 24'h00_0000;
         field_r    <= 1'b0;
      end
      else if (!enable)
      begin
         lineCnt_r  <= 16'h0000;
         lineIdx_r  <= 16'h0000;
         framePos_r <= 24'h00_0000;
         field_r    <= 1'b0;
      end
      else
      begin
         lineCnt_r  <= lineWrap ? 16'h0000 : lineCnt_r + 16'h0001;
         framePos_r <= frameWrap ? 24'h00_0000 : framePos_r + 24'h00_0001;
         if (frameWrap)
         begin
            lineIdx_r <= 16'h0000;
            field_r   <= encMode ? ~field_r : 1'b0;
         end
         else if (lineWrap)
            lineIdx_r <= lineIdx_r + 16'h0001;
      end
   end

   // ==========================================================
   // windows in half base-clock units
   assign fallHalf = ceilHalf(fallPoint_r, ratio_r);
   assign riseHalf = ceilHalf(risePoint_r, ratio_r);
   assign pclkOn   = widen(pclkOffset_r) + {15'h0000, fallHalf};
   assign pclkOff  = widen(pclkOffset_r) + {15'h0000, riseHalf};

   // encoder line sync is low for exactly one encoder clock at the row start
   assign hsOn  = encMode ? 25'h000_0000 : widen(hsOffset_r);
   assign hsOff = encMode ? {16'h0000, pixLen_r, 1'b0} : widen(hsOffset_r) + widen(hsWidth_r);

   // even field starts half a line later so the two falls do not coincide
   assign vsOn  = encMode ? (field_r ? widen(lineLen_r) : 25'h000_0000) : {1'b0, vsOffset_r};
   assign vsOff = vsOn + {1'b0, vsWidth_r};

   assign dvOn  = widen(dvOffset_r);
   assign dvOff = widen(dvOffset_r) + widen(dvWidth_r);

   assign rowActive = (lineIdx_r >= rowFirst_r) &&
                      ({1'b0, lineIdx_r} < ({1'b0, rowFirst_r} + {1'b0, rowCount_r}));
   assign encHsLow  = encMode && (lineCnt_r < {8'h00, pixLen_r});
   assign lineHalf  = {lineCnt_r, 1'b0};
   assign dvWhole   = (lineHalf >= {1'b0, dvOffset_r}) &&
                      (lineHalf < ({1'b0, dvOffset_r} + {1'b0, dvWidth_r}));

   // encoder mode forces fixed polarities
   assign hsAct = encMode ? 1'b0 : ctrl_r[`CTRL_HS_HIGH];
   assign vsAct = encMode ? 1'b0 : ctrl_r[`CTRL_VS_HIGH];
   assign dvAct = encMode ? 1'b1 : ctrl_r[`CTRL_DV_HIGH];

   // ==========================================================
   // component stream; data only changes on whole base clocks
   assign pixelTake = enable && (pixCnt_r == 8'h00) && rowActive && dvWhole && !encHsLow;

   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         pixelData <= 8'h00;
      else if (!enable)
         pixelData <= 8'h00;
      else if (pixelTake)
         pixelData <= pixelIn;
   end

   // ==========================================================
   // waveform generators
   half_step_gen pclkGen
   (
      .mclk     (mclk),
      .resetn   (resetn),
      .pos      ({16'h0000, pixCnt_r}),
      .onHalf   (pclkOn),
      .offHalf  (pclkOff),
      .gate     (enable),
      .actLevel (ctrl_r[`CTRL_PCLK_INV]),
      .pinOut   (panelPixelClock)
   );

   half_step_gen hsGen
   (
      .mclk     (mclk),
      .resetn   (resetn),
      .pos      ({8'h00, lineCnt_r}),
      .onHalf   (hsOn),
      .offHalf  (hsOff),
      .gate     (enable),
      .actLevel (hsAct),
      .pinOut   (lineSync)
   );

   half_step_gen vsGen
   (
      .mclk     (mclk),
      .resetn   (resetn),
      .pos      (framePos_r),
      .onHalf   (vsOn),
      .offHalf  (vsOff),
      .gate     (enable),
      .actLevel (vsAct),
      .pinOut   (frameSync)
   );

   // data-valid stays off outside active rows and during encoder line sync
   half_step_gen dvGen
   (
      .mclk     (mclk),
      .resetn   (resetn),
      .pos      ({8'h00, lineCnt_r}),
      .onHalf   (dvOn),
      .offHalf  (dvOff),
      .gate     (enable && rowActive && !encHsLow),
      .actLevel (dvAct),
      .pinOut   (dataValidStrobe)
   );
endmodule // sync_display_timing

// ---- testbench/display_timing_chk.sv ----
// Purpose: port-level assertions for the display timing generator
// Assumes: control and divisor writes are shadowed from the register port
// Notes:   encoder pulse checks only hold for the 4-clock divisor
`timescale 1ns/100ps
`include "display_timing_regs.vh"
module display_timing_chk
(
   input logic        mclk,
   input logic        resetn,
   input logic [4:0]  regAddr,
   input logic [31:0] regWdata,
   input logic        regWrite,
   input logic        regRead,
   input logic [31:0] regRdata,
   input logic [7:0]  pixelIn,
   input logic        pixelTake,
   input logic [7:0]  pixelData,
   input logic        lineSync,
   input logic        dataValidStrobe
);
   logic en_r;
   logic enc_r;
   logic div4_r;

   // ==================================================
   // shadow of control and divisor
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         en_r   <= 1'b0;
         enc_r  <= 1'b0;
         div4_r <= 1'b0;
      end
      else if (regWrite && regAddr == `REG_CTRL)
      begin
         en_r  <= regWdata[`CTRL_ENABLE];
         enc_r <= regWdata[`CTRL_ENABLE] & regWdata[`CTRL_ENCODER];
      end
      else if (regWrite && regAddr == `REG_DIVISOR)
         div4_r <= regWdata[11:0] == 12'h040;
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   // ==================================================
   // assertions
   sequence lineLowOne;
      (!lineSync) [*4] ##1 lineSync;
   endsequence
   sequence takeGap;
      (!pixelTake) [*3];
   endsequence

   a_rdata_idle:
      assert property (!$past(regRead) |-> regRdata == 32'h0000_0000) else $error("stray read data");
   a_unmapped_read:
      assert property ($past(regRead) && $past(regAddr) > `REG_STATUS |-> regRdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_take_idle:
      assert property (!en_r |-> !pixelTake) else $error("pixel taken while disabled");
   a_data_load:
      assert property (pixelTake |=> pixelData == $past(pixelIn)) else $error("pixel not loaded");
   a_data_hold:
      assert property ($past(en_r) && !$past(pixelTake) |-> $stable(pixelData)) else $error("pixel data moved");
   a_take_gap:
      assert property (en_r && div4_r && pixelTake |=> takeGap) else $error("two components in one clock");
   a_line_one_clk:
      assert property (enc_r && div4_r && $fell(lineSync) |-> lineLowOne) else $error("line sync width");
   a_dv_active:
      assert property (enc_r && dataValidStrobe |-> lineSync) else $error("data valid in sync");
endmodule // display_timing_chk

// ---- testbench/panel_model.sv ----
// Purpose: panel or encoder sink that timestamps pixel clock edges, sync falls, frame sync rises and data-valid rises
// Assumes: positive pixel clock polarity, data latched on its falling edge
// Notes:   only records; judging is left to the bench
`timescale 1ns/100ps
module panel_model
(
   input logic       panelPixelClock,
   input logic       lineSync,
   input logic       frameSync,
   input logic       dataValidStrobe,
   input logic [7:0] pixelData
);
   realtime    fallT[$];
   realtime    lowT[$];
   realtime    lineT[$];
   realtime    frameT[$];
   realtime    frameLowT[$];
   realtime    dvT[$];
   logic [7:0] got[$];

   // ==================================================
   // edge capture
   always @(negedge panelPixelClock)
   begin
      fallT.push_back($realtime);
      if (dataValidStrobe === 1'b1)
         got.push_back(pixelData);
   end
   always @(posedge panelPixelClock)
      if (fallT.size() > 0)
         lowT.push_back($realtime - fallT[$]);
   always @(negedge lineSync)
      lineT.push_back($realtime);
   always @(negedge frameSync)
      frameT.push_back($realtime);
   always @(posedge frameSync)
      if (frameT.size() > 0)
         frameLowT.push_back($realtime - frameT[$]);
   always @(posedge dataValidStrobe)
      dvT.push_back($realtime);

   task automatic clear();
      fallT.delete();
      lowT.delete();
      lineT.delete();
      frameT.delete();
      frameLowT.delete();
      dvT.delete();
      got.delete();
   endtask
endmodule // panel_model

// ---- testbench/testbench.sv ----
// Purpose: self-checking bench for the display timing generator
// Assumes: 100 MHz base clock; timing is programmed while disabled
// Notes:   pixel clock cases come from a table; encoder and reset cases follow
`timescale 1ns/100ps
`include "display_timing_regs.vh"
module testbench;
   typedef struct {
      logic [11:0] div;
      logic [7:0]  ratio;
      logic [7:0]  fall;
      logic [7:0]  rise;
      logic [15:0] off;
      int          lowNs;
      int          sumNs;
      int          pMin;
      int          pMax;
      int          phase;
   } row_t;
   // ratio 3 row: edge points only
   row_t        rows [4] = '{'{12'h040, 8'h01, 8'h02, 8'h04, 16'h0000, 20, 640, 40, 40, 5},
                             '{12'h040, 8'h03, 8'h02, 8'h04, 16'h0000, 5, 0, 0, 0, 5},
                             '{12'h038, 8'h01, 8'h01, 8'h02, 16'h0001, 10, 560, 30, 40, 0},
                             '{12'h03B, 8'h01, 8'h01, 8'h02, 16'h0000, 10, 590, 30, 40, 5}};
   logic [4:0]  addrs [9] = '{`REG_CTRL, `REG_DIVISOR, `REG_RATIO, `REG_FALL, `REG_RISE,
                              `REG_LINE_LEN, `REG_FRAME_LINES, `REG_HS_WIDTH, 5'h1F};
   logic [31:0] inits [9] = '{32'h0000_0000, 32'h0000_003B, 32'h0000_0001, 32'h0000_0002,
                              32'h0000_0004, 32'h0000_0010, 32'h0000_0004, 32'h0000_0002, 32'h0000_0000};
   logic        mclk = 1'b0;
   logic        resetn = 1'b0;
   logic [4:0]  regAddr = 5'h00;
   logic [31:0] regWdata = 32'h0000_0000;
   logic        regWrite = 1'b0;
   logic        regRead = 1'b0;
   logic [31:0] regRdata;
   logic [7:0]  pixelIn = 8'h00;
   logic        pixelTake;
   logic [7:0]  pixelData;
   logic        panelPixelClock;
   logic        lineSync;
   logic        frameSync;
   logic        dataValidStrobe;
   int          fails = 0;
   int          testsRun = 0;

   sync_display_timing i_dut
   (
      .mclk(mclk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
      .regRead(regRead), .regRdata(regRdata), .pixelIn(pixelIn), .pixelTake(pixelTake),
      .pixelData(pixelData), .panelPixelClock(panelPixelClock), .lineSync(lineSync),
      .frameSync(frameSync), .dataValidStrobe(dataValidStrobe)
   );
   panel_model i_panel
   (
      .panelPixelClock(panelPixelClock), .lineSync(lineSync), .frameSync(frameSync),
      .dataValidStrobe(dataValidStrobe), .pixelData(pixelData)
   );

   always #5 mclk = ~mclk;
   // user side hands a fresh component at every take
   always @(posedge mclk)
      if (pixelTake === 1'b1)
         pixelIn <= pixelIn + 8'h01;

   // ==================================================
   // bus and compare tasks
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge mclk);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      @(posedge mclk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge mclk);
      regRead <= 1'b0;
      #1 cmpVal(regRdata, e);
   endtask
   task automatic cmpVal(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmpRange(input int got, input int lo, input int hi);
      testsRun++;
      if (got < lo || got > hi)
      begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask
   task automatic cfg(input logic [11:0] dv, input logic [7:0] r, input logic [7:0] f,
                      input logic [7:0] u, input logic [15:0] o);
      wr(`REG_CTRL, 32'h0000_0000);
      wr(`REG_DIVISOR, {20'h0_0000, dv});
      wr(`REG_RATIO, {24'h00_0000, r});
      wr(`REG_FALL, {24'h00_0000, f});
      wr(`REG_RISE, {24'h00_0000, u});
      wr(`REG_PCLK_OFFSET, {16'h0000, o});
      wr(`REG_HS_OFFSET, {16'h0000, o});
      wr(`REG_VS_OFFSET, {16'h0000, o});
      wr(`REG_DV_OFFSET, {16'h0000, o});
   endtask
   task automatic rstCheck();
      resetn <= 1'b0;
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      repeat (2) @(posedge mclk);
      #1 cmpVal({27'h000_0000, panelPixelClock, lineSync, frameSync, dataValidStrobe, pixelTake}, 32'h0000_001E);
   endtask
   function automatic bit onLine(input realtime t);
      foreach (i_panel.lineT[k])
         if (i_panel.lineT[k] == t)
            return 1'b1;
      return 1'b0;
   endfunction
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", testsRun, fails);
      if (fails == 0 && testsRun > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ==================================================
   // main sequence
   initial
   begin
      int          ph;
      rstCheck();
      foreach (addrs[k])
         rd(addrs[k], inits[k]);
      wr(5'h1F, 32'hFFFF_FFFF);
      wr(`REG_STATUS, 32'hFFFF_FFFF);
      rd(`REG_STATUS, 32'h0000_0000);
      $display("test registers done");
      wr(`REG_ROW_COUNT, 32'h0000_0004);
      wr(`REG_DV_WIDTH, 32'h0000_0008);
      wr(`REG_VS_WIDTH, 32'h0000_0008);
      foreach (rows[i])
      begin
         cfg(rows[i].div, rows[i].ratio, rows[i].fall, rows[i].rise, rows[i].off);
         wr(`REG_CTRL, 32'h0000_0021);
         i_panel.clear();
         repeat (150) @(posedge mclk);
         ph = rows[i].off[0] ? 0 : 5;
         cmpVal($rtoi(i_panel.lowT[1]), rows[i].lowNs);
         cmpVal($rtoi(i_panel.fallT[1]) % 10, rows[i].phase);
         if (rows[i].sumNs != 0)
         begin
            cmpVal($rtoi(i_panel.fallT[17] - i_panel.fallT[1]), rows[i].sumNs);
            for (int k = 1; k < 17; k++)
               cmpRange($rtoi(i_panel.fallT[k + 1] - i_panel.fallT[k]), rows[i].pMin, rows[i].pMax);
         end
         cmpVal($rtoi(i_panel.lineT[2] - i_panel.lineT[1]), 160);
         cmpVal($rtoi(i_panel.frameT[1] - i_panel.frameT[0]), 640);
         cmpVal($rtoi(i_panel.lineT[0]) % 10, ph);
         cmpVal($rtoi(i_panel.frameT[0]) % 10, ph);
         cmpVal($rtoi(i_panel.dvT[0]) % 10, ph);
         $display("test pixel clock row %0d done", i);
      end
      // 16 periods at 27 MHz minus and plus ten percent
      cmpRange($rtoi(i_panel.fallT[17] - i_panel.fallT[1]), 539, 658);
      cfg(12'h040, 8'h01, 8'h02, 8'h04, 16'h0000);
      wr(`REG_LINE_LEN, 32'h0000_0020);
      wr(`REG_DV_OFFSET, 32'h0000_0008);
      wr(`REG_CTRL, 32'h0000_0022);
      wr(`REG_CTRL, 32'h0000_0023);
      i_panel.clear();
      repeat (420) @(posedge mclk);
      cmpVal($rtoi(i_panel.lineT[2] - i_panel.lineT[1]), 320);
      cmpVal(onLine(i_panel.frameT[0]), 1);
      cmpVal(onLine(i_panel.frameT[1]), 0);
      cmpRange($rtoi(i_panel.frameLowT[0]), 10, 100000);
      cmpVal(i_panel.got.size() > 0, 1);
      $display("test encoder done");
      rstCheck();
      i_panel.clear();
      repeat (40) @(posedge mclk);
      cmpVal(i_panel.lineT.size() + i_panel.fallT.size(), 0);
      rd(`REG_CTRL, 32'h0000_0000);
      $display("test reset done");
      tally_and_finish();
   end

   // work ends well within 2000 cycles
   initial
   begin
      #100000;
      fails++;
      tally_and_finish();
   end
endmodule // testbench

bind sync_display_timing display_timing_chk i_chk
(
   .mclk(mclk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
   .regRead(regRead), .regRdata(regRdata), .pixelIn(pixelIn), .pixelTake(pixelTake),
   .pixelData(pixelData), .lineSync(lineSync), .dataValidStrobe(dataValidStrobe)
);
